// >>> core/pecfm_pkg.sv
// Package for the protection enable and charge switch action mask block.
`default_nettype none
package pecfm_pkg;
  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] OFF_TEMP_EN = 4'h0;
  localparam logic [3:0] OFF_LATCH_EN = 4'h1;
  localparam logic [3:0] OFF_CHG_MASK_A = 4'h2;
  localparam logic [3:0] OFF_CHG_MASK_B = 4'h3;
  localparam logic [3:0] OFF_CHG_MASK_C = 4'h4;
  localparam logic [3:0] OFF_SAFETY = 4'h5;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h6;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h7;
  localparam logic [3:0] OFF_STATE = 4'h8;
  // ---------------------------------------------------------------------
  // Reset values and writable bits
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_TEMP_EN = 8'h00;
  localparam logic [7:0] RST_LATCH_EN = 8'h00;
  localparam logic [7:0] RST_CHG_MASK_A = 8'h98;
  localparam logic [7:0] RST_CHG_MASK_B = 8'hd5;
  localparam logic [7:0] RST_CHG_MASK_C = 8'h56;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] VALID_TEMP_EN = 8'hf7;
  localparam logic [7:0] VALID_LATCH_EN = 8'hf6;
  localparam logic [7:0] VALID_CHG_MASK_A = 8'h98;
  localparam logic [7:0] VALID_CHG_MASK_B = 8'hd5;
  localparam logic [7:0] VALID_CHG_MASK_C = 8'h56;
  localparam logic [7:0] FAST_MASK_A_FULL = 8'h98;
  localparam logic [7:0] FAST_MASK_A_LOW = 8'h18;
  // ---------------------------------------------------------------------
  // Field positions of byte B and byte C
  // ---------------------------------------------------------------------
  localparam int B_SWITCH_OVERTEMP = 7;
  localparam int B_DIE_OVERTEMP = 6;
  localparam int B_DISCHARGE_OVERTEMP = 5;
  localparam int B_CHARGE_OVERTEMP = 4;
  localparam int B_DIE_UNDERTEMP = 2;
  localparam int B_DISCHARGE_UNDERTEMP = 1;
  localparam int B_CHARGE_UNDERTEMP = 0;
  localparam int C_OVERCURRENT_TIER3 = 7;
  localparam int C_SHORT_CIRCUIT_LATCH = 6;
  localparam int C_OVERCURRENT_LATCH = 5;
  localparam int C_CELL_OVERVOLTAGE_LATCH = 4;
  localparam int C_PRECHARGE_TIMEOUT = 2;
  localparam int C_HOST_WATCHDOG_FAULT = 1;
  // ---------------------------------------------------------------------
  // Interrupt status bits
  // ---------------------------------------------------------------------
  localparam int IRQ_TEMP_FLAG = 0;
  localparam int IRQ_LATCH_FLAG = 1;
  localparam int IRQ_CHG_OFF = 2;
  localparam int IRQ_SLOW_MASK = 3;
  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_NORMAL_MS = 250;
  localparam int DELAY_SLEEP_MS = 1;
  localparam int DELAY_NORMAL_CYC = DELAY_NORMAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DELAY_SLEEP_CYC = DELAY_SLEEP_MS * 1000000000 / CLK_PERIOD_NS;
  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pecfm_bus_req_t;
  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] latch;
    logic [7:0] other;
  } pecfm_flags_t;
  typedef enum logic [1:0] {
    PECFM_IDLE = 2'b00,
    PECFM_WAIT = 2'b01,
    PECFM_OFF = 2'b11
  } pecfm_state_t;
endpackage : pecfm_pkg
`default_nettype wire

// >>> core/pecfm_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module pecfm_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : pecfm_sync
`default_nettype wire

// >>> core/pecfm_delay.sv
// Turnoff postponement counter used when action mask A is not a fast pattern.
`timescale 1ns/100ps
`default_nettype none
module pecfm_delay #(
  parameter int NORMAL_CYC = pecfm_pkg::DELAY_NORMAL_CYC,
  parameter int SLEEP_CYC = pecfm_pkg::DELAY_SLEEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic sleep,
  output logic done
);
  logic [27:0] cnt_r;
  logic [27:0] lim;

  assign lim = sleep ? 28'(SLEEP_CYC) : 28'(NORMAL_CYC);
  assign done = start && (cnt_r >= lim - 28'h1);

  // The count restarts whenever the slow request falls away.
  always_ff @(posedge clk) begin
    if (!rst_n || !start) begin
      cnt_r <= '0;
    end else if (!done) begin
      cnt_r <= cnt_r + 28'h1;
    end
  end
endmodule : pecfm_delay
`default_nettype wire

// >>> core/pecfm_top.sv
// Protection enable bytes, charge switch action masks and charge switch control.
// What this block does
// [RULE_01] Enabled protections alone raise safety flags; the other flags have no enable here and always follow their detectors
// [RULE_02] Temperature enable byte resets zero, high bits
// [RULE_03] Temperature enable low bits, bit three reserved
// [RULE_04] Latch enable byte resets zero, high bits
// [RULE_05] Precharge timeout bit2, watchdog bit1 enables
// [RULE_06] Switch action uses action masks, not enables
// [RULE_07] Mask A resets 0x98, bits 7,4,3 act
// [RULE_08] Software keeps mask A at 0x98 or 0x18
// [RULE_09] Other mask A values may postpone turnoff
// [RULE_10] Masks B and C act immediately per bit
// [RULE_11] Mask B resets 0xd5 with temperature bits
// [RULE_12] Mask C resets 0x56 with latch bits
// [RULE_13] Flagged and masked protection turns switch off
// [RULE_14] Reserved bits read zero, have no effect
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pecfm_top #(
  parameter int NORMAL_CYC = pecfm_pkg::DELAY_NORMAL_CYC,
  parameter int SLEEP_CYC = pecfm_pkg::DELAY_SLEEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire pecfm_pkg::pecfm_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Protection detectors, asynchronous
  input wire pecfm_pkg::pecfm_flags_t detect,
  input wire logic sleep_mode,
  // Outputs
  output var pecfm_pkg::pecfm_flags_t safety_status,
  output logic charge_switch_off,
  output logic irq
);
  // ---------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------
  logic [24:0] det_s;
  pecfm_pkg::pecfm_flags_t det;
  logic sleep_s;

  pecfm_sync #(.WIDTH(25)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({sleep_mode, detect}),
    .dout(det_s)
  );
  assign det = det_s[23:0];
  assign sleep_s = det_s[24];

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------
  logic [7:0] temp_en_r;
  logic [7:0] latch_en_r;
  logic [7:0] mask_a_r;
  logic [7:0] mask_b_r;
  logic [7:0] mask_c_r;
  logic [7:0] irq_mask_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_stat_nxt;
  logic [7:0] irq_evt;
  logic wr_en;

  assign wr_en = bus_req.wr && !bus_req.rd;

  // Reserved bits are forced to zero on write so they never steer anything.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      temp_en_r <= pecfm_pkg::RST_TEMP_EN; // RULE_02
      latch_en_r <= pecfm_pkg::RST_LATCH_EN; // RULE_04
      mask_a_r <= pecfm_pkg::RST_CHG_MASK_A; // RULE_07
      mask_b_r <= pecfm_pkg::RST_CHG_MASK_B; // RULE_11
      mask_c_r <= pecfm_pkg::RST_CHG_MASK_C; // RULE_12
      irq_mask_r <= pecfm_pkg::RST_IRQ_MASK;
    end else if (wr_en) begin
      unique case (bus_req.addr)
        pecfm_pkg::OFF_TEMP_EN: begin
          temp_en_r <= bus_req.wdata & pecfm_pkg::VALID_TEMP_EN; // RULE_03
        end
        pecfm_pkg::OFF_LATCH_EN: begin
          latch_en_r <= bus_req.wdata & pecfm_pkg::VALID_LATCH_EN; // RULE_05
        end
        pecfm_pkg::OFF_CHG_MASK_A: begin
          mask_a_r <= bus_req.wdata & pecfm_pkg::VALID_CHG_MASK_A; // RULE_14
        end
        pecfm_pkg::OFF_CHG_MASK_B: begin
          mask_b_r <= bus_req.wdata & pecfm_pkg::VALID_CHG_MASK_B; // RULE_14
        end
        pecfm_pkg::OFF_CHG_MASK_C: begin
          mask_c_r <= bus_req.wdata & pecfm_pkg::VALID_CHG_MASK_C; // RULE_14
        end
        pecfm_pkg::OFF_IRQ_MASK: begin
          irq_mask_r <= bus_req.wdata & 8'h0f;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Safety status flags
  // ---------------------------------------------------------------------
  // Each temperature and latch flag follows its detector only while its enable bit is set; the other flags always follow theirs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      safety_status <= '0;
    end else begin
      safety_status.temp <= det.temp & temp_en_r; // RULE_01
      safety_status.latch <= det.latch & latch_en_r; // RULE_01
      safety_status.other <= det.other;
    end
  end

  // ---------------------------------------------------------------------
  // Charge switch decision
  // ---------------------------------------------------------------------
  logic fast_hit;
  logic slow_hit;
  logic mask_a_fast;
  logic delay_done;
  pecfm_pkg::pecfm_state_t state_r;

  assign mask_a_fast = (mask_a_r == pecfm_pkg::FAST_MASK_A_FULL) ||
                       (mask_a_r == pecfm_pkg::FAST_MASK_A_LOW); // RULE_09
  assign fast_hit = |(safety_status.temp & mask_b_r) ||
                    |(safety_status.latch & mask_c_r) ||
                    (mask_a_fast && |(safety_status.other & mask_a_r)); // RULE_10
  assign slow_hit = !mask_a_fast && |(safety_status.other & mask_a_r); // RULE_06

  pecfm_delay #(.NORMAL_CYC(NORMAL_CYC), .SLEEP_CYC(SLEEP_CYC)) u_delay (
    .clk(clk),
    .rst_n(rst_n),
    .start(slow_hit),
    .sleep(sleep_s),
    .done(delay_done)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= pecfm_pkg::PECFM_IDLE;
    end else begin
      unique case (state_r)
        pecfm_pkg::PECFM_IDLE: begin
          if (fast_hit) begin
            state_r <= pecfm_pkg::PECFM_OFF;
          end else if (slow_hit) begin
            state_r <= pecfm_pkg::PECFM_WAIT;
          end
        end
        pecfm_pkg::PECFM_WAIT: begin
          if (fast_hit || delay_done) begin
            state_r <= pecfm_pkg::PECFM_OFF;
          end else if (!slow_hit) begin
            state_r <= pecfm_pkg::PECFM_IDLE;
          end
        end
        pecfm_pkg::PECFM_OFF: begin
          if (!fast_hit && !slow_hit) begin
            state_r <= pecfm_pkg::PECFM_IDLE;
          end
        end
        default: begin
          state_r <= pecfm_pkg::PECFM_IDLE;
        end
      endcase
    end
  end

  // The switch follows the state so it stays off while any masked flag stands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      charge_switch_off <= 1'b0;
    end else begin
      charge_switch_off <= fast_hit ||
                           (state_r == pecfm_pkg::PECFM_WAIT && slow_hit && delay_done) ||
                           (state_r == pecfm_pkg::PECFM_OFF && slow_hit); // RULE_13
    end
  end

  // ---------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------
  always_comb begin
    irq_evt = 8'h00;
    irq_evt[pecfm_pkg::IRQ_TEMP_FLAG] = |safety_status.temp;
    irq_evt[pecfm_pkg::IRQ_LATCH_FLAG] = |safety_status.latch;
    irq_evt[pecfm_pkg::IRQ_CHG_OFF] = charge_switch_off;
    irq_evt[pecfm_pkg::IRQ_SLOW_MASK] = !mask_a_fast;
    irq_stat_nxt = irq_stat_r;
    if (wr_en && bus_req.addr == pecfm_pkg::OFF_IRQ_STATUS) begin
      irq_stat_nxt = irq_stat_r & ~bus_req.wdata;
    end
    // A new event wins over a clear in the same cycle.
    irq_stat_nxt = irq_stat_nxt | irq_evt;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_r <= 8'h00;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        pecfm_pkg::OFF_TEMP_EN: bus_rdata <= temp_en_r;
        pecfm_pkg::OFF_LATCH_EN: bus_rdata <= latch_en_r;
        pecfm_pkg::OFF_CHG_MASK_A: bus_rdata <= mask_a_r;
        pecfm_pkg::OFF_CHG_MASK_B: bus_rdata <= mask_b_r;
        pecfm_pkg::OFF_CHG_MASK_C: bus_rdata <= mask_c_r;
        pecfm_pkg::OFF_SAFETY: bus_rdata <= safety_status.temp | safety_status.latch;
        pecfm_pkg::OFF_IRQ_STATUS: bus_rdata <= irq_stat_r;
        pecfm_pkg::OFF_IRQ_MASK: bus_rdata <= irq_mask_r;
        pecfm_pkg::OFF_STATE: bus_rdata <= {5'h00, charge_switch_off, state_r};
        default: bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_flag_gated: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    (safety_status.temp & ~$past(temp_en_r)) == 8'h00)
    else $error("Temperature flag set while its protection is disabled.");
  a_latch_gated: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    (safety_status.latch & ~$past(latch_en_r)) == 8'h00)
    else $error("Latch flag set while its protection is disabled.");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (temp_en_r[3] == 1'b0) && (latch_en_r & 8'h09) == 8'h00)
    else $error("Reserved enable bit became set.");
  a_masks_clean: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
    (mask_a_r & ~pecfm_pkg::VALID_CHG_MASK_A) == 8'h00 &&
    (mask_b_r & ~pecfm_pkg::VALID_CHG_MASK_B) == 8'h00 &&
    (mask_c_r & ~pecfm_pkg::VALID_CHG_MASK_C) == 8'h00)
    else $error("Reserved action mask bit became set.");
  // Reset values are checked at the first edge that sees reset released.
  a_reset_vals: assert property (@(posedge clk) // RULE_07
    $rose(rst_n) |-> mask_a_r == pecfm_pkg::RST_CHG_MASK_A &&
    mask_b_r == pecfm_pkg::RST_CHG_MASK_B && mask_c_r == pecfm_pkg::RST_CHG_MASK_C)
    else $error("Action masks do not hold their reset values.");
  a_fast_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    (|(safety_status.temp & mask_b_r) || |(safety_status.latch & mask_c_r))
    |=> charge_switch_off)
    else $error("Charge switch not off one cycle after an immediate fault.");
  a_off_cause: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    charge_switch_off |-> $past(fast_hit) || $past(slow_hit))
    else $error("Charge switch off without a masked flag.");
  a_slow_wait: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    slow_hit && !fast_hit && state_r == pecfm_pkg::PECFM_IDLE |=> !charge_switch_off)
    else $error("Postponed turnoff happened at once.");
  a_enable_reset: assert property (@(posedge clk) // RULE_02
    $rose(rst_n) |-> temp_en_r == 8'h00 && latch_en_r == 8'h00)
    else $error("Enable bytes do not reset to zero.");
  // The postponed path has two steps: the request enters the wait, then the wait ends.
  sequence s_slow_start;
    state_r == pecfm_pkg::PECFM_IDLE && slow_hit && !fast_hit;
  endsequence
  sequence s_slow_waiting;
    state_r == pecfm_pkg::PECFM_WAIT && !charge_switch_off;
  endsequence
  sequence s_slow_expired;
    state_r == pecfm_pkg::PECFM_WAIT && slow_hit && delay_done;
  endsequence
  a_slow_enter: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    s_slow_start |=> s_slow_waiting)
    else $error("Postponed request did not enter the wait.");
  a_slow_expire: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    s_slow_expired |=> charge_switch_off && state_r == pecfm_pkg::PECFM_OFF)
    else $error("Charge switch not off when the postponement ran out.");
  a_switch_release: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    !fast_hit && !slow_hit |=> !charge_switch_off)
    else $error("Charge switch held off with no masked flag.");
  a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && !$past(wr_en && bus_req.addr == pecfm_pkg::OFF_IRQ_STATUS) |->
    (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r))
    else $error("Interrupt status bit dropped without a clear.");
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(wr_en && bus_req.addr == pecfm_pkg::OFF_IRQ_STATUS) |->
    (irq_stat_r & $past(irq_evt)) == $past(irq_evt))
    else $error("Interrupt event lost to a clear in the same cycle.");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("Read data did not return to zero after the read cycle.");
endmodule : pecfm_top
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking testbench for the protection enable and charge switch action mask block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  localparam int NCYC = 20;
  localparam int SCYC = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pecfm_pkg::pecfm_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  pecfm_pkg::pecfm_flags_t detect = '0;
  logic sleep_mode = 1'b0;
  pecfm_pkg::pecfm_flags_t safety_status;
  logic charge_switch_off;
  logic irq;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] bitv;
  logic [7:0] rnd;
  int fails = 0;
  int tests_run = 0;
  int seed = 61;

  always #5 clk = ~clk;

  pecfm_top #(.NORMAL_CYC(NCYC), .SLEEP_CYC(SCYC)) dut (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .detect(detect),
    .sleep_mode(sleep_mode),
    .safety_status(safety_status),
    .charge_switch_off(charge_switch_off),
    .irq(irq)
  );

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    bus_req <= '0;
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
  endtask : wr

  // The expected value is noted here and compared by the watcher below.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    exp_q.push_back(e);
    @(posedge clk);
  endtask : rd

  task automatic expect_off(input logic e);
    cyc(6);
    check({7'h00, charge_switch_off}, {7'h00, e});
  endtask : expect_off

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------
  // Read data watcher
  // ---------------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("mismatch at %0t: got %h expected %h", $time, bus_rdata, 8'h00);
      end else begin
        check(bus_rdata, exp_q.pop_front());
      end
    end
    rd_seen <= bus_req.rd;
  end

  initial begin
    #50000;
    fails++;
    test_done();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(pecfm_pkg::OFF_TEMP_EN, 8'h00);
    rd(pecfm_pkg::OFF_LATCH_EN, 8'h00);
    rd(pecfm_pkg::OFF_CHG_MASK_A, 8'h98);
    rd(pecfm_pkg::OFF_CHG_MASK_B, 8'hd5);
    rd(pecfm_pkg::OFF_CHG_MASK_C, 8'h56);
    rd(4'hf, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(i[3:0], 8'hff);
    end
    rd(pecfm_pkg::OFF_TEMP_EN, 8'hf7);
    rd(pecfm_pkg::OFF_LATCH_EN, 8'hf6);
    rd(pecfm_pkg::OFF_CHG_MASK_A, 8'h98);
    rd(pecfm_pkg::OFF_CHG_MASK_B, 8'hd5);
    rd(pecfm_pkg::OFF_CHG_MASK_C, 8'h56);
    for (int i = 0; i < 8; i++) begin
      rnd = 8'($random(seed));
      wr(pecfm_pkg::OFF_TEMP_EN, rnd);
      rd(pecfm_pkg::OFF_TEMP_EN, rnd & 8'hf7);
    end
    // Detections with every protection disabled must leave flags and switch alone.
    wr(pecfm_pkg::OFF_TEMP_EN, 8'h00);
    wr(pecfm_pkg::OFF_LATCH_EN, 8'h00);
    detect <= '{temp: 8'hff, latch: 8'hff, other: 8'h00};
    expect_off(1'b0);
    check(safety_status.temp, 8'h00);
    check(safety_status.latch, 8'h00);
    wr(pecfm_pkg::OFF_TEMP_EN, 8'hff);
    wr(pecfm_pkg::OFF_LATCH_EN, 8'hff);
    expect_off(1'b1);
    check(safety_status.temp, 8'hf7);
    check(safety_status.latch, 8'hf6);
    rd(pecfm_pkg::OFF_SAFETY, 8'hf7);
    detect <= '{temp: 8'h08, latch: 8'h09, other: 8'h00};
    expect_off(1'b0);
    // Each action bit of masks B and C alone turns the switch off.
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 8; i++) begin
        bitv = 8'h01 << i;
        if (((k == 0) ? pecfm_pkg::VALID_CHG_MASK_B : pecfm_pkg::VALID_CHG_MASK_C) & bitv) begin
          wr((k == 0) ? pecfm_pkg::OFF_CHG_MASK_C : pecfm_pkg::OFF_CHG_MASK_B, 8'h00);
          wr((k == 0) ? pecfm_pkg::OFF_CHG_MASK_B : pecfm_pkg::OFF_CHG_MASK_C, bitv);
          detect <= '{temp: (k == 0) ? bitv : 8'h00, latch: (k == 1) ? bitv : 8'h00,
                      other: 8'h00};
          expect_off(1'b1);
          wr((k == 0) ? pecfm_pkg::OFF_CHG_MASK_B : pecfm_pkg::OFF_CHG_MASK_C, ~bitv);
          expect_off(1'b0);
          detect <= '0;
        end
      end
    end
    wr(pecfm_pkg::OFF_CHG_MASK_B, 8'h00);
    wr(pecfm_pkg::OFF_CHG_MASK_C, 8'h00);
    // Fast patterns of mask A.
    wr(pecfm_pkg::OFF_CHG_MASK_A, pecfm_pkg::FAST_MASK_A_LOW);
    detect <= '{temp: 8'h00, latch: 8'h00, other: 8'h80};
    expect_off(1'b0);
    detect <= '{temp: 8'h00, latch: 8'h00, other: 8'h10};
    expect_off(1'b1);
    detect <= '{temp: 8'h00, latch: 8'h00, other: 8'h08};
    expect_off(1'b1);
    wr(pecfm_pkg::OFF_CHG_MASK_A, pecfm_pkg::FAST_MASK_A_FULL);
    detect <= '{temp: 8'h00, latch: 8'h00, other: 8'h80};
    expect_off(1'b1);
    check(safety_status.other, 8'h80);
    rd(pecfm_pkg::OFF_STATE, 8'h07);
    // Other mask A values postpone the turnoff, longer in sleep operation.
    detect <= '0;
    wr(pecfm_pkg::OFF_CHG_MASK_A, 8'h08);
    expect_off(1'b0);
    detect <= '{temp: 8'h00, latch: 8'h00, other: 8'h08};
    expect_off(1'b0);
    rd(pecfm_pkg::OFF_STATE, 8'h01);
    cyc(NCYC + 4);
    check({7'h00, charge_switch_off}, 8'h01);
    detect <= '0;
    sleep_mode <= 1'b1;
    expect_off(1'b0);
    detect <= '{temp: 8'h00, latch: 8'h00, other: 8'h08};
    cyc(NCYC + 6);
    check({7'h00, charge_switch_off}, 8'h00);
    cyc(SCYC);
    check({7'h00, charge_switch_off}, 8'h01);
    // Interrupt: raise, mask, unmask and clear.
    detect <= '0;
    sleep_mode <= 1'b0;
    wr(pecfm_pkg::OFF_CHG_MASK_A, 8'h98);
    cyc(6);
    rd(pecfm_pkg::OFF_IRQ_STATUS, 8'h0f);
    wr(pecfm_pkg::OFF_IRQ_STATUS, 8'hff);
    rd(pecfm_pkg::OFF_IRQ_STATUS, 8'h00);
    wr(pecfm_pkg::OFF_IRQ_MASK, 8'h04);
    detect <= '{temp: 8'h00, latch: 8'h40, other: 8'h00};
    cyc(6);
    check({7'h00, irq}, 8'h00);
    // A clear while the latch flag still stands leaves the status bit set.
    wr(pecfm_pkg::OFF_IRQ_STATUS, 8'h02);
    rd(pecfm_pkg::OFF_IRQ_STATUS, 8'h02);
    wr(pecfm_pkg::OFF_IRQ_MASK, 8'h02);
    detect <= '0;
    cyc(6);
    check({7'h00, irq}, 8'h01);
    rd(pecfm_pkg::OFF_IRQ_MASK, 8'h02);
    wr(pecfm_pkg::OFF_IRQ_STATUS, 8'h02);
    cyc(3);
    check({7'h00, irq}, 8'h00);
    rd(pecfm_pkg::OFF_IRQ_STATUS, 8'h00);
    // A reset in mid-run brings mask B, both enable bytes and the interrupt mask back to their reset values.
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    rd(pecfm_pkg::OFF_CHG_MASK_B, 8'hd5);
    rd(pecfm_pkg::OFF_TEMP_EN, 8'h00);
    rd(pecfm_pkg::OFF_LATCH_EN, 8'h00);
    rd(pecfm_pkg::OFF_IRQ_MASK, 8'h00);
    cyc(3);
    if (exp_q.size() != 0) begin
      fails++;
    end
    test_done();
  end
endmodule : tb_top
`default_nettype wire
